// ### hw/hia_host_map.v
// Host side of the graphics controller: bus, map, interrupts, pixel formats
//
// Function
// - Five interrupt sources raise requests, each enabled by the interrupt mask register.
// - Device withholds ready while a read or write cannot complete at once.
// - Large maps start with register windows at 1FC0000, 64 KB then 32 KB windows.
// - Writing 1 to bit 0 at offset 005Ch relocates windows, large maps only.
// - Relocated windows sit at 03FC0000 through 03FF8000; memory starts at zero.
// - Graphics memory appears linearly in host address space.
// - Drawing frame up to 4096x4096, 32-pixel units, 8 or 16 bits per pixel.
// - Up to six display layers are supported.
// - Depth is unsigned, two bytes per pixel in 16-bit mode, one in 8-bit.
// - Flag buffer holds one bit per pixel plus one extra line each side.
// - 16-bit direct pixel has 5-bit red, green, blue and bit 15 alpha.
// - 16-bit texture bit 15 is the stencil alpha, only while texture mapping.
// - Indexed pixels, textures and cursors are 8-bit indices; two 64x64 cursors.
// - Texture patterns up to 4096x4096 in 16-bit direct or 8-bit indexed form.
// - Capture stores 4:2:2, two pixels per word, chroma low and luma high.
// - 32-bit pixel has 8-bit colours, bit 31 alpha, reserved bits above.
`timescale 1ns/100ps
`include "hia_consts.vh"
module hia_host_map #(
   parameter AW = 26
) (
   // Clock and reset
   input  wire          i_mclk,
   input  wire          i_sys_rst,
   // Map strap
   input  wire          i_large_map,
   // Host bus
   input  wire          i_host_cs_n,
   input  wire          i_host_rd_n,
   input  wire          i_host_wr_n,
   input  wire [AW-1:0] i_host_addr,
   input  wire [3:0]    i_host_be_n,
   input  wire [31:0]   i_host_wdata,
   output reg  [31:0]   o_host_rdata,
   output reg           o_host_ready_line_n,
   output reg           o_host_irq,
   // Interrupt sources
   input  wire [4:0]    i_irq_src,
   // Graphics memory port
   output reg           o_mem_req,
   output reg           o_mem_we,
   output reg  [AW-1:0] o_mem_addr,
   output reg  [3:0]    o_mem_be,
   output reg  [31:0]   o_mem_wdata,
   input  wire          i_mem_ack,
   input  wire [31:0]   i_mem_rdata,
   // Register block port
   output reg           o_blk_req,
   output reg  [3:0]    o_blk_sel,
   output reg           o_blk_we,
   output reg  [15:0]   o_blk_addr,
   output reg  [3:0]    o_blk_be,
   output reg  [31:0]   o_blk_wdata,
   input  wire          i_blk_ack,
   input  wire [31:0]   i_blk_rdata,
   // Frame geometry
   output reg  [13:0]   o_draw_pitch,
   output reg  [13:0]   o_zbuf_pitch,
   output reg  [7:0]    o_flag_pitch,
   output reg  [12:0]   o_flag_lines,
   output reg  [2:0]    o_layer_count,
   output reg           o_reloc,
   // Pixel conversion
   input  wire [1:0]    i_cnv_mode,
   input  wire          i_cnv_texmap,
   input  wire [31:0]   i_cnv_px,
   output reg  [7:0]    o_cnv_r,
   output reg  [7:0]    o_cnv_g,
   output reg  [7:0]    o_cnv_b,
   output reg  [7:0]    o_cnv_index,
   output reg           o_cnv_alpha,
   // Capture packing
   input  wire [7:0]    i_cap_y0,
   input  wire [7:0]    i_cap_y1,
   input  wire [7:0]    i_cap_cb,
   input  wire [7:0]    i_cap_cr,
   output reg  [31:0]   o_cap_word
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_DONE = 2'h2;
   localparam ST_REL  = 2'h3;

   reg  [1:0]    state_q;
   reg  [1:0]    state_d;
   reg  [4:0]    int_mask_q;
   reg  [4:0]    istat_q;
   reg           reloc_q;
   reg  [18:0]   frame_q;
   reg           we_q;
   reg  [31:0]   rdata_d;

   wire          strobe;
   wire [5:0]    sel;
   wire [AW-1:0] ofs;
   wire          hreg_wr;
   wire [31:0]   wmask;
   wire [31:0]   wbits;
   wire [31:0]   mask_mrg;
   wire [31:0]   frame_mrg;

   // Expand 5-bit colour to 8 bits by bit replication
   function [7:0] hia_x5;
      input [4:0] v;
      begin
         hia_x5 = {v, v[4:2]};
      end
   endfunction

   // Merge a write under byte enables
   function [31:0] hia_merge;
      input [31:0] old;
      input [31:0] nw;
      input [31:0] m;
      begin
         hia_merge = (old & ~m) | (nw & m);
      end
   endfunction

   // Frame width in 32-pixel units from the stored count minus one
   function [7:0] hia_units;
      input [6:0] u;
      begin
         hia_units = {1'b0, u} + 8'h01;
      end
   endfunction

   assign strobe  = !i_host_cs_n && (!i_host_rd_n || !i_host_wr_n);
   assign hreg_wr = (state_q == ST_IDLE) && strobe && !i_host_wr_n && sel[1];
   assign wmask   = {{8{!i_host_be_n[3]}}, {8{!i_host_be_n[2]}},
                     {8{!i_host_be_n[1]}}, {8{!i_host_be_n[0]}}};
   assign wbits   = i_host_wdata & wmask;
   assign mask_mrg  = hia_merge({27'h0000000, int_mask_q}, i_host_wdata, wmask);
   assign frame_mrg = hia_merge({13'h0000, frame_q}, i_host_wdata, wmask);

   hia_addr_dec i_hia_addr_dec (
      .i_addr      (i_host_addr),
      .i_large_map (i_large_map),
      .i_reloc     (reloc_q),
      .o_sel       (sel),
      .o_ofs       (ofs)
   );

   // Host interface register reads
   always @* begin
      rdata_d = 32'h00000000;
      case (ofs[15:0])
         `HIA_REG_INT_MASK: rdata_d = {27'h0000000, int_mask_q};
         `HIA_REG_ISTAT: rdata_d = {27'h0000000, istat_q};
         `HIA_REG_RELOC: rdata_d = {31'h00000000, reloc_q};
         `HIA_REG_FRAME: rdata_d = {13'h0000, frame_q};
         default:        rdata_d = 32'h00000000;
      endcase
   end

   // Host access sequencer
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (strobe) begin
               state_d = sel[1] ? ST_DONE : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if ((o_mem_req && i_mem_ack) || (o_blk_req && i_blk_ack)) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: state_d = ST_REL;
         ST_REL: begin
            if (!strobe) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state_q             <= ST_IDLE;
         we_q                <= 1'b0;
         o_host_rdata        <= 32'h00000000;
         o_host_ready_line_n <= 1'b1;
         o_mem_req           <= 1'b0;
         o_mem_we            <= 1'b0;
         o_mem_addr          <= {AW{1'b0}};
         o_mem_be            <= 4'h0;
         o_mem_wdata         <= 32'h00000000;
         o_blk_req           <= 1'b0;
         o_blk_sel           <= 4'h0;
         o_blk_we            <= 1'b0;
         o_blk_addr          <= 16'h0000;
         o_blk_be            <= 4'h0;
         o_blk_wdata         <= 32'h00000000;
      end else begin
         state_q             <= state_d;
         // Ready stays withheld until the access has completed
         o_host_ready_line_n <= !(state_d == ST_DONE);
         case (state_q)
            ST_IDLE: begin
               we_q <= !i_host_wr_n;
               if (strobe && sel[1]) begin
                  o_host_rdata <= rdata_d;
               end
               if (strobe && sel[0]) begin
                  // Memory is linear: host address is the memory address
                  o_mem_req   <= 1'b1;
                  o_mem_we    <= !i_host_wr_n;
                  o_mem_addr  <= i_host_addr;
                  o_mem_be    <= i_host_wr_n ? 4'hF : ~i_host_be_n;
                  o_mem_wdata <= i_host_wdata;
               end
               if (strobe && (sel[5:2] != 4'h0)) begin
                  o_blk_req   <= 1'b1;
                  o_blk_sel   <= sel[5:2];
                  o_blk_we    <= !i_host_wr_n;
                  o_blk_addr  <= {1'b0, ofs[14:0]};
                  o_blk_be    <= i_host_wr_n ? 4'hF : ~i_host_be_n;
                  o_blk_wdata <= i_host_wdata;
               end
            end
            ST_WAIT: begin
               if (o_mem_req && i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  if (!we_q) begin
                     o_host_rdata <= i_mem_rdata;
                  end
               end
               if (o_blk_req && i_blk_ack) begin
                  o_blk_req <= 1'b0;
                  if (!we_q) begin
                     o_host_rdata <= i_blk_rdata;
                  end
               end
            end
            default: begin
               o_mem_req <= 1'b0;
               o_blk_req <= 1'b0;
            end
         endcase
      end
   end

   // Host interface registers and interrupt state
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         int_mask_q <= `HIA_RST_INT_MASK;
         istat_q    <= 5'h00;
         reloc_q    <= 1'b0;
         frame_q    <= `HIA_RST_FRAME;
         o_host_irq <= 1'b0;
         o_reloc    <= 1'b0;
      end else begin
         // Sticky sources; a new event beats a write-one clear
         if (hreg_wr && ofs[15:0] == `HIA_REG_ISTAT) begin
            istat_q <= (istat_q & ~wbits[4:0]) | i_irq_src;
         end else begin
            istat_q <= istat_q | i_irq_src;
         end
         if (hreg_wr && ofs[15:0] == `HIA_REG_INT_MASK) begin
            int_mask_q <= mask_mrg[4:0];
         end
         if (hreg_wr && ofs[15:0] == `HIA_REG_FRAME) begin
            frame_q <= frame_mrg[18:0];
         end
         // Relocation only takes effect on the large maps; the host must
         // hold off its next access while the window moves
         if (hreg_wr && ofs[15:0] == `HIA_REG_RELOC && !i_host_be_n[0]) begin
            reloc_q <= i_large_map & i_host_wdata[0];
         end
         if (!i_large_map) begin
            reloc_q <= 1'b0;
         end
         o_host_irq <= |(istat_q & int_mask_q);
         o_reloc    <= reloc_q;
      end
   end

   // Frame geometry from the frame configuration register
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_draw_pitch  <= 14'h0000;
         o_zbuf_pitch  <= 14'h0000;
         o_flag_pitch  <= 8'h00;
         o_flag_lines  <= 13'h0000;
         o_layer_count <= 3'h0;
      end else begin
         // Width in 32-pixel units, up to 128 units of 32 pixels
         o_draw_pitch <= frame_q[`HIA_FRM_D16] ?
                         {hia_units(frame_q[6:0]), 6'h00} :
                         {1'b0, hia_units(frame_q[6:0]), 5'h00};
         // Depth: two bytes per pixel in 16-bit mode, one in 8-bit mode
         o_zbuf_pitch <= frame_q[`HIA_FRM_Z16] ?
                         {hia_units(frame_q[6:0]), 6'h00} :
                         {1'b0, hia_units(frame_q[6:0]), 5'h00};
         // One flag word covers 32 pixels, bit n for pixel n
         o_flag_pitch <= hia_units(frame_q[6:0]);
         // Height in lines plus one guard line above and below
         o_flag_lines <= {1'b0, frame_q[13:7], 5'h00} + 13'h0022;
         if (frame_q[17:15] > `HIA_MAX_LAYERS) begin
            o_layer_count <= `HIA_MAX_LAYERS;
         end else begin
            o_layer_count <= frame_q[17:15];
         end
      end
   end

   // Pixel unpacking for every stored colour format
   always @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_cnv_r     <= 8'h00;
         o_cnv_g     <= 8'h00;
         o_cnv_b     <= 8'h00;
         o_cnv_index <= 8'h00;
         o_cnv_alpha <= 1'b0;
         o_cap_word  <= 32'h00000000;
      end else begin
         o_cnv_r     <= 8'h00;
         o_cnv_g     <= 8'h00;
         o_cnv_b     <= 8'h00;
         o_cnv_index <= 8'h00;
         o_cnv_alpha <= 1'b0;
         case (i_cnv_mode)
            `HIA_CNV_IDX8: begin
               o_cnv_index <= i_cnv_px[7:0];
            end
            `HIA_CNV_D16: begin
               o_cnv_r     <= hia_x5(i_cnv_px[`HIA_PX16_R_LSB +: 5]);
               o_cnv_g     <= hia_x5(i_cnv_px[`HIA_PX16_G_LSB +: 5]);
               o_cnv_b     <= hia_x5(i_cnv_px[`HIA_PX16_B_LSB +: 5]);
               o_cnv_alpha <= i_cnv_px[`HIA_PX16_ALPHA];
            end
            `HIA_CNV_D32: begin
               // Bits 30..24 are reserved and ignored
               o_cnv_r     <= i_cnv_px[`HIA_PX32_R_LSB +: 8];
               o_cnv_g     <= i_cnv_px[`HIA_PX32_G_LSB +: 8];
               o_cnv_b     <= i_cnv_px[`HIA_PX32_B_LSB +: 8];
               o_cnv_alpha <= i_cnv_px[`HIA_PX32_ALPHA];
            end
            `HIA_CNV_TEX16: begin
               o_cnv_r     <= hia_x5(i_cnv_px[`HIA_PX16_R_LSB +: 5]);
               o_cnv_g     <= hia_x5(i_cnv_px[`HIA_PX16_G_LSB +: 5]);
               o_cnv_b     <= hia_x5(i_cnv_px[`HIA_PX16_B_LSB +: 5]);
               // Stencil flag only counts during texture mapping
               o_cnv_alpha <= i_cnv_texmap & i_cnv_px[`HIA_PX16_ALPHA];
            end
            default: begin
               o_cnv_alpha <= 1'b0;
            end
         endcase
         // Two pixels per word: Cb with Y0 low, Cr with Y1 high
         o_cap_word <= {i_cap_y1, i_cap_cr, i_cap_y0, i_cap_cb};
      end
   end
endmodule // hia_host_map

// ### hw/hia_consts.vh
// Constants for the host address map and pixel format block
`ifndef HIA_CONSTS_VH
`define HIA_CONSTS_VH
// Register window base of each map, byte addresses
`define HIA_BASE_SMALL     26'h0FC0000
`define HIA_BASE_LARGE     26'h1FC0000
`define HIA_BASE_RELOC     26'h3FC0000
// Window offsets from the host interface window base
`define HIA_OFS_DISP       26'h0010000
`define HIA_OFS_CAP        26'h0018000
`define HIA_OFS_GAP        26'h0020000
`define HIA_OFS_DRAW       26'h0030000
`define HIA_OFS_GEOM       26'h0038000
`define HIA_OFS_END        26'h0040000
// Host interface register offsets
`define HIA_REG_INT_MASK   16'h0020
`define HIA_REG_ISTAT      16'h0024
`define HIA_REG_RELOC      16'h005C
`define HIA_REG_FRAME      16'h0060
// Reset values
`define HIA_RST_INT_MASK   5'h00
`define HIA_RST_FRAME      19'h00000
// Interrupt source bits
`define HIA_IRQ_VSYNC      0
`define HIA_IRQ_FSYNC      1
`define HIA_IRQ_SYNCERR    2
`define HIA_IRQ_CMDERR     3
`define HIA_IRQ_CMDEND     4
// Frame configuration fields
`define HIA_FRM_W_LSB      0
`define HIA_FRM_H_LSB      7
`define HIA_FRM_D16        14
`define HIA_FRM_LAY_LSB    15
`define HIA_FRM_Z16        18
`define HIA_FRM_UNIT_PX    32
`define HIA_MAX_LAYERS     3'h6
// Pixel format fields
`define HIA_PX16_ALPHA     15
`define HIA_PX16_R_LSB     10
`define HIA_PX16_G_LSB     5
`define HIA_PX16_B_LSB     0
`define HIA_PX32_ALPHA     31
`define HIA_PX32_R_LSB     16
`define HIA_PX32_G_LSB     8
`define HIA_PX32_B_LSB     0
// Conversion modes
`define HIA_CNV_IDX8       2'h0
`define HIA_CNV_D16        2'h1
`define HIA_CNV_D32        2'h2
`define HIA_CNV_TEX16      2'h3
`endif

// ### hw/hia_addr_dec.v
// Host address decoder for register windows and graphics memory
`timescale 1ns/100ps
`include "hia_consts.vh"
module hia_addr_dec (
   // Address and map
   input  wire [25:0] i_addr,
   input  wire        i_large_map,
   input  wire        i_reloc,
   // Decode
   output reg  [5:0]  o_sel,
   output wire [25:0] o_ofs
);
   reg  [25:0] base;
   always @* begin
      if (!i_large_map) begin
         base = `HIA_BASE_SMALL;
      end else if (i_reloc) begin
         base = `HIA_BASE_RELOC;
      end else begin
         base = `HIA_BASE_LARGE;
      end
   end
   assign o_ofs = i_addr - base;
   // One-hot: 0 memory, 1 host, 2 display, 3 capture, 4 drawing, 5 geometry
   always @* begin
      o_sel = 6'h01;
      if (i_addr >= base) begin
         if (o_ofs < `HIA_OFS_DISP) begin
            o_sel = 6'h02;
         end else if (o_ofs < `HIA_OFS_CAP) begin
            o_sel = 6'h04;
         end else if (o_ofs < `HIA_OFS_GAP) begin
            o_sel = 6'h08;
         end else if (o_ofs >= `HIA_OFS_DRAW && o_ofs < `HIA_OFS_GEOM) begin
            o_sel = 6'h10;
         end else if (o_ofs >= `HIA_OFS_GEOM && o_ofs < `HIA_OFS_END) begin
            o_sel = 6'h20;
         end
      end
   end
endmodule // hia_addr_dec

// ### verif/hia_host_cpu.sv
// Host processor model driving the SRAM-style bus
`timescale 1ns/100ps
module hia_host_cpu #(
   // Pulsed ready is the normally-not-ready style: one ignored sample
   parameter SW_WAIT = 1
) (
   // Clock
   input  wire        i_mclk,
   // Host bus
   input  wire        i_ready_n,
   input  wire [31:0] i_rdata,
   output reg         o_cs_n,
   output reg         o_rd_n,
   output reg         o_wr_n,
   output reg  [25:0] o_addr,
   output reg  [3:0]  o_be_n,
   output reg  [31:0] o_wdata
);
   initial begin
      {o_cs_n, o_rd_n, o_wr_n, o_be_n} = 7'h7F;
      o_addr = 26'h0;
      o_wdata = 32'h0;
   end
   // One access: strobes and qualifiers held until ready is sampled low
   task access(input wr, input [25:0] a, input [31:0] d, output [31:0] q, output ok);
      integer n;
      begin
         repeat (2) @(posedge i_mclk);
         {o_cs_n, o_rd_n, o_wr_n, o_be_n} <= {1'b0, wr, !wr, 4'h0};
         o_addr <= a;
         o_wdata <= d;
         repeat (SW_WAIT) @(posedge i_mclk);
         n = 0;
         do begin
            @(posedge i_mclk);
            n = n + 1;
         end while (i_ready_n !== 1'b0 && n < 200);
         ok = (n < 200);
         q = i_rdata;
         {o_cs_n, o_rd_n, o_wr_n, o_be_n} <= 7'h7F;
         o_addr <= ~a;
         o_wdata <= ~d;
         if (wr && d[0] && a[15:0] == 16'h005C) repeat (20) @(posedge i_mclk);
      end
   endtask
endmodule // hia_host_cpu

// ### verif/hia_host_map_chk.sv
// Assertions on the ports of the host map block
`timescale 1ns/100ps
module hia_host_map_chk #(
   parameter AW = 26
) (
   input wire          i_mclk, i_sys_rst, i_mem_ack, i_blk_ack, i_cnv_texmap,
   input wire          o_host_ready_line_n, o_mem_req, o_blk_req, o_cnv_alpha,
   input wire [AW-1:0] o_mem_addr,
   input wire [3:0]    o_blk_sel,
   input wire [2:0]    o_layer_count,
   input wire [1:0]    i_cnv_mode,
   input wire [31:0]   i_cnv_px, o_cap_word,
   input wire [7:0]    o_cnv_r, o_cnv_b, o_cnv_index, i_cap_y0, i_cap_y1, i_cap_cb, i_cap_cr
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   sequence s_mem_done; o_mem_req && i_mem_ack; endsequence
   sequence s_blk_done; o_blk_req && i_blk_ack; endsequence
   sequence s_rdy_pulse; !o_host_ready_line_n ##1 o_host_ready_line_n; endsequence
   AST_MEM_READY: assert property (s_mem_done |=> !o_mem_req ##0 s_rdy_pulse)
      else $error("memory ack not followed by one ready pulse");
   AST_BLK_READY: assert property (s_blk_done |=> !o_blk_req ##0 s_rdy_pulse)
      else $error("block ack not followed by one ready pulse");
   AST_MEM_WAIT: assert property (o_mem_req && !i_mem_ack |=>
      o_host_ready_line_n && o_mem_req && $stable(o_mem_addr))
      else $error("memory request dropped or ready given early");
   AST_BLK_WAIT: assert property (o_blk_req && !i_blk_ack |=> o_host_ready_line_n && o_blk_req)
      else $error("block request dropped or ready given early");
   AST_BLK_ONEHOT: assert property (o_blk_req |-> $onehot(o_blk_sel))
      else $error("block select not one-hot");
   AST_LAYER_MAX: assert property (o_layer_count <= 3'h6)
      else $error("layer count above six");
   AST_CAP_PACK: assert property (1'b1 |=>
      o_cap_word == {$past(i_cap_y1), $past(i_cap_cr), $past(i_cap_y0), $past(i_cap_cb)})
      else $error("capture word packing");
   AST_CNV16: assert property (i_cnv_mode == 2'h1 |=> o_cnv_alpha == $past(i_cnv_px[15]) &&
      o_cnv_r == {$past(i_cnv_px[14:10]), $past(i_cnv_px[14:12])})
      else $error("16-bit pixel conversion");
   AST_CNV32: assert property (i_cnv_mode == 2'h2 |=> o_cnv_alpha == $past(i_cnv_px[31]) &&
      o_cnv_r == $past(i_cnv_px[23:16]) && o_cnv_b == $past(i_cnv_px[7:0]))
      else $error("32-bit pixel conversion");
   AST_TEX_ALPHA: assert property (i_cnv_mode == 2'h3 |=>
      o_cnv_alpha == ($past(i_cnv_px[15]) & $past(i_cnv_texmap)))
      else $error("texture alpha outside texture mapping");
   AST_INDEX: assert property (i_cnv_mode == 2'h0 |=> o_cnv_index == $past(i_cnv_px[7:0]))
      else $error("index conversion");
endmodule // hia_host_map_chk
bind hia_host_map hia_host_map_chk #(.AW(AW)) i_hia_host_map_chk (.i_mclk, .i_sys_rst,
   .i_mem_ack, .i_blk_ack, .i_cnv_texmap, .o_host_ready_line_n, .o_mem_req, .o_blk_req,
   .o_cnv_alpha, .o_mem_addr, .o_blk_sel, .o_layer_count, .i_cnv_mode, .i_cnv_px, .o_cap_word,
   .o_cnv_r, .o_cnv_b, .o_cnv_index, .i_cap_y0, .i_cap_y1, .i_cap_cb, .i_cap_cr);

// ### verif/hia_host_map_tb.sv
// Self-checking testbench for the host map block
`timescale 1ns/100ps
module hia_host_map_tb;
   reg         i_mclk, i_sys_rst, i_large_map, i_mem_ack, i_blk_ack, i_cnv_texmap;
   reg  [4:0]  i_irq_src;
   reg  [31:0] i_mem_rdata, i_blk_rdata, i_cnv_px, q, last_wd;
   reg  [1:0]  i_cnv_mode;
   reg  [7:0]  i_cap_y0, i_cap_y1, i_cap_cb, i_cap_cr;
   wire        i_host_cs_n, i_host_rd_n, i_host_wr_n, o_host_ready_line_n, o_host_irq;
   wire        o_mem_req, o_mem_we, o_blk_req, o_blk_we, o_reloc, o_cnv_alpha;
   wire [25:0] i_host_addr, o_mem_addr;
   wire [3:0]  i_host_be_n, o_mem_be, o_blk_sel, o_blk_be;
   wire [31:0] i_host_wdata, o_host_rdata, o_mem_wdata, o_blk_wdata, o_cap_word;
   wire [15:0] o_blk_addr;
   wire [13:0] o_draw_pitch, o_zbuf_pitch;
   wire [7:0]  o_flag_pitch, o_cnv_r, o_cnv_g, o_cnv_b, o_cnv_index;
   wire [12:0] o_flag_lines;
   wire [2:0]  o_layer_count;
   integer     errors, checked, seed, k, w, h;
   reg  [25:0] base, last_addr;
   reg  [4:0]  last_kind;
   reg  [3:0]  last_be;
   reg         ok, last_we;

   hia_host_map i_hia_host_map (.*);
   hia_host_cpu i_hia_host_cpu (.i_mclk(i_mclk), .i_ready_n(o_host_ready_line_n),
      .i_rdata(o_host_rdata), .o_cs_n(i_host_cs_n), .o_rd_n(i_host_rd_n), .o_wr_n(i_host_wr_n),
      .o_addr(i_host_addr), .o_be_n(i_host_be_n), .o_wdata(i_host_wdata));

   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end
   function [31:0] pat(input [25:0] a);
      pat = {a[15:0], ~a[15:0]} ^ 32'h3C5A0000;
   endfunction
   function [4:0] win(input [25:0] a);
      reg [25:0] o;
      begin
         o = a - base;
         if (a < base || o >= 26'h40000 || (o >= 26'h20000 && o < 26'h30000)) win = 5'h00;
         else if (o < 26'h10000) win = 5'h1F;
         else win = 5'h01 << {o[17], o[15]};
      end
   endfunction
   function [24:0] exp16(input m, input t, input [15:0] p);
      exp16 = {p[15] & (!m | t), p[14:10], p[14:12], p[9:5], p[9:7], p[4:0], p[4:2]};
   endfunction
   // Memory and register blocks answer after a random delay
   always @(posedge i_mclk) begin
      i_mem_ack <= 1'b0;
      i_blk_ack <= 1'b0;
      i_mem_rdata <= ~i_mem_rdata;
      i_blk_rdata <= ~i_blk_rdata;
      if (o_mem_req && !i_mem_ack && ($random(seed) & 3) == 0) begin
         i_mem_ack <= 1'b1;
         i_mem_rdata <= pat(o_mem_addr);
         {last_kind, last_addr, last_wd, last_be, last_we} <=
            {5'h00, o_mem_addr, o_mem_wdata, o_mem_be, o_mem_we};
      end
      if (o_blk_req && !i_blk_ack && ($random(seed) & 3) == 0) begin
         i_blk_ack <= 1'b1;
         i_blk_rdata <= pat({11'h0, o_blk_addr[14:0]});
         {last_kind, last_addr, last_wd, last_be, last_we} <=
            {1'b0, o_blk_sel, 10'h0, o_blk_addr, o_blk_wdata, o_blk_be, o_blk_we};
      end
   end
   task chk(input c, input [8*12-1:0] m);
      begin
         checked = checked + 1;
         if (c !== 1'b1) begin
            errors = errors + 1;
            $display("wrong value at %0t: %0s", $time, m);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge i_mclk);
         #1;
      end
   endtask
   task hreg(input wr, input [15:0] o, input [31:0] d);
      begin
         i_hia_host_cpu.access(wr, base + {10'h0, o}, d, q, ok);
         chk(ok === 1'b1, "ready");
      end
   endtask
   task one(input [25:0] a);
      reg [4:0]  kind;
      reg        wr;
      reg [31:0] d;
      begin
         kind = win(a);
         wr = $random(seed);
         d = $random(seed);
         last_kind = 5'h1E;
         i_hia_host_cpu.access(wr, a, d, q, ok);
         chk(ok === 1'b1 && last_kind === kind && last_we === wr, "route");
         chk(last_addr[14:2] === a[14:2] && (kind != 0 || last_addr[25:15] === a[25:15]), "addr");
         if (wr) chk(last_wd === d && last_be === 4'hF, "wdata");
         else chk(q === pat(kind ? {11'h0, a[14:0]} : a) && last_be === 4'hF, "rdata");
      end
   endtask
   task rand_access(input integer n);
      reg [25:0] a;
      integer    i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            a = $random(seed);
            if ($random(seed) & 1) a = base + 26'h10000 + (a % 26'h30000);
            if (win(a) == 5'h1F) a = a ^ 26'h20000;
            a[1:0] = 2'b00;
            one(a);
         end
      end
   endtask
   task end_of_test;
      begin
         if (errors == 0 && checked > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      repeat (30000) @(posedge i_mclk);
      errors = errors + 1;
      end_of_test;
   end
   initial begin
      seed = 32'hf811e827;
      {errors, checked} = 0;
      {i_sys_rst, i_large_map, i_mem_ack, i_blk_ack, i_cnv_texmap} = 5'h19;
      {i_irq_src, i_mem_rdata, i_blk_rdata, i_cnv_px, i_cnv_mode} = 0;
      {i_cap_y0, i_cap_y1, i_cap_cb, i_cap_cr} = 32'h0;
      base = 26'h1FC0000;
      repeat (5) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      tick(1);
      chk(o_host_ready_line_n === 1'b1 && o_reloc === 1'b0 && o_host_irq === 1'b0, "reset");
      rand_access(40);
      hreg(1, 16'h0020, 32'h15);
      hreg(0, 16'h0020, 32'h0);
      chk(q[4:0] === 5'h15, "mask");
      for (k = 0; k < 5; k = k + 1) begin
         @(posedge i_mclk) i_irq_src <= 5'h01 << k;
         @(posedge i_mclk) i_irq_src <= 5'h00;
         tick(3);
         chk(o_host_irq === ((5'h15 >> k) % 2 == 1), "irq");
         hreg(0, 16'h0024, 32'h0);
         chk(q[4:0] === (5'h01 << k), "status");
         hreg(1, 16'h0024, 32'h1F);
         tick(2);
         chk(o_host_irq === 1'b0, "irq clear");
      end
      for (k = 0; k < 2; k = k + 1) begin
         w = k ? 127 : 5;
         h = k ? 127 : 0;
         hreg(1, 16'h0060, {13'h0, k[0], k ? 3'h7 : 3'h3, k[0], h[6:0], w[6:0]});
         tick(3);
         chk(o_draw_pitch === 14'((w + 1) * 32 * (k + 1)), "draw");
         chk(o_zbuf_pitch === 14'((w + 1) * 32 * (k + 1)), "depth");
         chk(o_flag_pitch === 8'(w + 1) && o_flag_lines === 13'((h + 1) * 32 + 2), "flag");
         chk(o_layer_count === (k ? 3'h6 : 3'h3), "layers");
      end
      last_kind = 5'h1E;
      i_hia_host_cpu.access(1'b1, 26'h0000100, 32'h0, q, ok);
      chk(ok === 1'b1 && last_wd === 32'h0 && last_kind === 5'h00, "clear");
      hreg(1, 16'h005C, 32'h1);
      tick(1);
      chk(o_reloc === 1'b1, "reloc");
      base = 26'h3FC0000;
      hreg(0, 16'h005C, 32'h0);
      chk(q[0] === 1'b1, "reloc read");
      one(26'h1FD0000);
      one(26'h3FF8000);
      rand_access(30);
      @(posedge i_mclk) {i_sys_rst, i_large_map} <= 2'b10;
      repeat (2) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      base = 26'h0FC0000;
      hreg(1, 16'h005C, 32'h1);
      hreg(0, 16'h005C, 32'h0);
      chk(q[0] === 1'b0 && o_reloc === 1'b0, "no reloc");
      rand_access(30);
      for (k = 0; k < 40; k = k + 1) begin
         @(posedge i_mclk);
         i_cnv_mode <= k[1:0];
         i_cnv_px <= $random(seed);
         i_cnv_texmap <= $random(seed);
         {i_cap_y0, i_cap_y1, i_cap_cb, i_cap_cr} <= $random(seed);
         tick(1);
         if (i_cnv_mode == 2'h0) chk(o_cnv_index === i_cnv_px[7:0], "index");
         else if (i_cnv_mode == 2'h2)
            chk({o_cnv_alpha, o_cnv_r, o_cnv_g, o_cnv_b} === {i_cnv_px[31], i_cnv_px[23:0]}, "rgb32");
         else chk({o_cnv_alpha, o_cnv_r, o_cnv_g, o_cnv_b} ===
            exp16(i_cnv_mode[1], i_cnv_texmap, i_cnv_px[15:0]), "rgb16");
         chk(o_cap_word === {i_cap_y1, i_cap_cr, i_cap_y0, i_cap_cb}, "capture");
      end
      end_of_test;
   end
endmodule // hia_host_map_tb
